// File: hdl/rmc_defs.svh
/*
  register offsets, field positions and reset values of the regulator
  mode control register bank.
  assumes it is included by bare name from the package and the modules.
*/
// Contract
// - startup sequencer reloads each buck mode field from its sequencer enable bit (aps or off).
// - a buck enabled by the sequencer gets auto pulse-skip mode.
// - buck 1a: mode 3-0 (0xa), hold 4, user-off 5, speed 7-6 (0x1).
// - buck two: mode 17-14 (0xa), hold 18, user-off 19, speed 21-20; 13-8 unused.
// - buck three: mode 3-0 (0xa), hold 4, user-off 5; hold/off on power-off only.
// - buck 4a: mode 9-6 (0xa), hold 10, user-off 11.
// - buck 4b: mode 15-12 (0xa), hold 16, user-off 17.
// - buck five: mode 21-18 (0xa), hold 22, user-off 23.
// - usb supply enable bit 3 resets to 1 and is forced 1 on invalid vbus.
// - bit 11 reflects pass device strap for general linear two.
// - bit 17 reflects the same strap for the usb aux linear.
// - boost standby mode 6-5 and normal mode 3-2 reset to 0x2; 1-0 not reset.
// - linear standby-control bits 1,5,13,16,19 clear on system reset.
// - bit 2 selects usb bus role and is untouched by register reset.
// - voltage select fields 2-0,5-4,8-6,10-9,12-11; bits 3 and 23-13 unused.
`ifndef RMC_DEFS_SVH
`define RMC_DEFS_SVH
`define RMC_AW          8
`define RMC_DW          24
`define RMC_OFF_BUCK2   8'h1c
`define RMC_OFF_BUCK3   8'h1d
`define RMC_OFF_LVSEL   8'h1e
`define RMC_OFF_BOOST   8'h1f
`define RMC_OFF_LMODE   8'h20
`define RMC_MODE_DEF    4'ha
`define RMC_MODE_APS    4'h8
`define RMC_MODE_OFF    4'h0
`define RMC_SPEED_DEF   2'h1
`define RMC_BST_DEF     2'h2
// writable masks; spare bits 4 and 7 of boost are plain storage
`define RMC_MASK_BUCK2  24'hffc0ff
`define RMC_MASK_BUCK3  24'hffffff
`define RMC_MASK_LVSEL  24'h001ff7
`define RMC_MASK_BOOST  24'h0000ff
`define RMC_MASK_LMODE  24'h1ffc7f
// bits loaded with their reset values by system reset (mode/speed/standby fields)
`define RMC_SYS_BUCK2   24'hffc0cf
`define RMC_SYS_BUCK3   24'h3cf3cf
`define RMC_SYS_BOOST   24'h0000fc
`define RMC_SYS_LMODE   24'h19606a
// bits cleared by power-off reset (hold and user-off)
`define RMC_OFF_MASK2   24'h0c0030
`define RMC_OFF_MASK3   24'hc30c30
`define RMC_RST_BUCK2   24'h52804a
`define RMC_RST_BUCK3   24'h28a28a
`define RMC_RST_BOOST   24'h000048
`define RMC_RST_LMODE   24'h000008
`define RMC_BIT_USBON   3
`define RMC_BIT_USBROLE 2
`define RMC_BIT_G2PASS  11
`define RMC_BIT_U2PASS  17
`endif

// File: hdl/rmc_pkg.sv
/*
  types of the regulator mode control register bank.
  assumes rmc_defs.svh is on the include path.
*/
`include "rmc_defs.svh"
package rmc_pkg;
  typedef struct packed {
    logic [`RMC_AW-1:0] addr;
    logic [`RMC_DW-1:0] wdata;
    logic               wr;
    logic               rd;
  } rmc_req_t;
  typedef struct packed {
    logic       load;
    logic [5:0] buck_on;
    logic [7:0] lvsel;
    logic [1:0] boost_set;
    logic [6:0] lin_on;
    logic       usb_role;
  } rmc_seq_t;
  typedef enum logic [1:0] {
    RMC_SEQ_IDLE = 2'b00,
    RMC_SEQ_LOAD = 2'b01,
    RMC_SEQ_DONE = 2'b10
  } rmc_seq_state_t;
endpackage

// File: hdl/rmc_strap_load.sv
/*
  holds a one-shot start-up load pulse: the sequencer's request is taken
  once after system reset release, together with the pass strap level.
  assumes strap and request are synchronous to clk.
*/
`timescale 1ns/1ns
module rmc_strap_load (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic seq_req,
  input  wire logic strap_in,
  output logic      load_pulse,
  output logic      strap_reg
);
  import rmc_pkg::*;
  rmc_seq_state_t state_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= RMC_SEQ_IDLE;
    end else begin
      case (state_reg)
        RMC_SEQ_IDLE: if (seq_req) state_reg <= RMC_SEQ_LOAD;
        RMC_SEQ_LOAD: state_reg <= RMC_SEQ_DONE;
        default:      state_reg <= RMC_SEQ_DONE;
      endcase
    end
  end
  // strap caught by a clocked process, never by the reset itself
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_reg <= 1'b0;
    end else if (state_reg == RMC_SEQ_IDLE && seq_req) begin
      strap_reg <= strap_in;
    end
  end
  assign load_pulse = (state_reg == RMC_SEQ_LOAD);
endmodule

// File: hdl/rmc_regs.sv
/*
  regulator mode control register bank: five 24-bit registers with a
  system reset, a power-off reset and start-up sequencer loading.
  assumes a simple strobe port; read data appear one cycle after rd.
*/
`timescale 1ns/1ns
`include "rmc_defs.svh"
module rmc_regs (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             power_off_rst,
  input  wire rmc_pkg::rmc_req_t bus,
  input  wire rmc_pkg::rmc_seq_t seq,
  input  wire logic             seq_req,
  input  wire logic             pass_device_strap,
  input  wire logic             vbus_invalid,
  output logic [`RMC_DW-1:0]    rdata,
  output logic [`RMC_DW-1:0]    buck_pair_mode_ctrl,
  output logic [`RMC_DW-1:0]    buck_trio_mode_ctrl,
  output logic [`RMC_DW-1:0]    linear_voltage_select,
  output logic [`RMC_DW-1:0]    boost_ctrl,
  output logic [`RMC_DW-1:0]    linear_mode_ctrl,
  output logic                  load_done
);
  import rmc_pkg::*;

  logic [`RMC_DW-1:0] b2_reg;
  logic [`RMC_DW-1:0] b3_reg;
  logic [`RMC_DW-1:0] lv_reg;
  logic [`RMC_DW-1:0] bst_reg;
  logic [`RMC_DW-1:0] lm_reg;
  logic [`RMC_DW-1:0] rdata_next;
  logic               load_pulse;
  logic               strap_reg;
  logic [`RMC_DW-1:0] wd;
  logic               w_b2;
  logic               w_b3;
  logic               w_lv;
  logic               w_bst;
  logic               w_lm;

  rmc_strap_load u_load (
    .clk        (clk),
    .rst        (rst),
    .seq_req    (seq_req),
    .strap_in   (pass_device_strap),
    .load_pulse (load_pulse),
    .strap_reg  (strap_reg)
  );

  function automatic logic [`RMC_DW-1:0] merge(
    input logic [`RMC_DW-1:0] old_v,
    input logic [`RMC_DW-1:0] new_v,
    input logic [`RMC_DW-1:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  // aps for an enabled buck, off otherwise
  function automatic logic [3:0] seq_mode(input logic on);
    seq_mode = on ? `RMC_MODE_APS : `RMC_MODE_OFF;
  endfunction

  assign wd = bus.wdata;

  always_comb begin
    w_b2  = 1'b0;
    w_b3  = 1'b0;
    w_lv  = 1'b0;
    w_bst = 1'b0;
    w_lm  = 1'b0;
    if (!bus.wr) begin
      w_b2 = 1'b0;
    end else if (bus.addr == `RMC_OFF_BUCK2) begin
      w_b2 = 1'b1;
    end else if (bus.addr == `RMC_OFF_BUCK3) begin
      w_b3 = 1'b1;
    end else if (bus.addr == `RMC_OFF_LVSEL) begin
      w_lv = 1'b1;
    end else if (bus.addr == `RMC_OFF_BOOST) begin
      w_bst = 1'b1;
    end else if (bus.addr == `RMC_OFF_LMODE) begin
      w_lm = 1'b1;
    end
  end

  // system-reset fields of the first buck register; hold/off kept apart
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      b2_reg <= `RMC_RST_BUCK2;
    end else if (load_pulse) begin
      b2_reg[3:0]   <= seq_mode(seq.buck_on[0]);
      b2_reg[17:14] <= seq_mode(seq.buck_on[1]);
    end else if (w_b2) begin
      b2_reg <= merge(b2_reg, wd, `RMC_SYS_BUCK2);
    end
  end

  logic [`RMC_DW-1:0] off_reg;
  // hold and user-off bits of the first buck register, power-off reset only
  always_ff @(posedge clk or posedge power_off_rst) begin
    if (power_off_rst) begin
      off_reg <= '0;
    end else if (w_b2) begin
      off_reg <= merge(off_reg, wd, `RMC_OFF_MASK2);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      b3_reg <= `RMC_RST_BUCK3;
    end else if (load_pulse) begin
      b3_reg[3:0]   <= seq_mode(seq.buck_on[2]);
      b3_reg[9:6]   <= seq_mode(seq.buck_on[3]);
      b3_reg[15:12] <= seq_mode(seq.buck_on[4]);
      b3_reg[21:18] <= seq_mode(seq.buck_on[5]);
    end else if (w_b3) begin
      b3_reg <= merge(b3_reg, wd, `RMC_SYS_BUCK3);
    end
  end

  // second register's hold/off pairs kept apart so a write there
  // never disturbs the first register's pairs
  logic [`RMC_DW-1:0] b2_view;
  logic [`RMC_DW-1:0] b3_view;
  logic [`RMC_DW-1:0] b3_off;
  always_ff @(posedge clk or posedge power_off_rst) begin
    if (power_off_rst) begin
      b3_off <= '0;
    end else if (w_b3) begin
      b3_off <= merge(b3_off, wd, `RMC_OFF_MASK3);
    end
  end
  assign b2_view = (b2_reg & `RMC_SYS_BUCK2 & ~`RMC_OFF_MASK2)
                 | (off_reg & `RMC_OFF_MASK2);
  assign b3_view = (b3_reg & ~`RMC_OFF_MASK3) | (b3_off & `RMC_OFF_MASK3);

  // voltage selects: cleared by system reset, sequencer loads bits 12-11 and 9-4
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lv_reg <= '0;
    end else if (load_pulse) begin
      lv_reg <= merge(lv_reg, {11'h0, seq.lvsel[7:6], 1'b0, seq.lvsel[5:0],
                               4'h0}, `RMC_MASK_LVSEL);
    end else if (w_lv) begin
      lv_reg <= merge(lv_reg, wd, `RMC_MASK_LVSEL);
    end
  end

  // boost output setting is not touched by reset
  logic [1:0] bst_set_reg;
  always_ff @(posedge clk) begin
    if (load_pulse) begin
      bst_set_reg <= seq.boost_set;
    end else if (w_bst) begin
      bst_set_reg <= wd[1:0];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bst_reg <= `RMC_RST_BOOST;
    end else if (w_bst) begin
      bst_reg <= merge(bst_reg, wd, `RMC_SYS_BOOST);
    end
  end

  // usb role bit survives register reset
  logic usb_role_reg;
  always_ff @(posedge clk) begin
    if (load_pulse) begin
      usb_role_reg <= seq.usb_role;
    end else if (w_lm) begin
      usb_role_reg <= wd[`RMC_BIT_USBROLE];
    end
  end

  // system-reset fields of the linear mode register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lm_reg <= `RMC_RST_LMODE;
    end else begin
      if (w_lm && !load_pulse) begin
        lm_reg <= merge(lm_reg, wd, `RMC_SYS_LMODE);
      end
      // invalid vbus wins over a software write
      if (vbus_invalid) begin
        lm_reg[`RMC_BIT_USBON] <= 1'b1;
      end
    end
  end

  // enables and pass selects survive reset; the sequencer loads them
  logic [`RMC_DW-1:0] lm_keep_reg;
  always_ff @(posedge clk) begin
    if (load_pulse) begin
      lm_keep_reg[0]  <= seq.lin_on[0];
      lm_keep_reg[4]  <= seq.lin_on[1];
      lm_keep_reg[10] <= seq.lin_on[2];
      lm_keep_reg[12] <= seq.lin_on[3];
      lm_keep_reg[15] <= seq.lin_on[4];
      lm_keep_reg[18] <= seq.lin_on[5];
      lm_keep_reg[`RMC_BIT_G2PASS] <= strap_reg;
      lm_keep_reg[`RMC_BIT_U2PASS] <= strap_reg;
    end else if (w_lm) begin
      lm_keep_reg <= merge(lm_keep_reg, wd,
                           `RMC_MASK_LMODE & ~`RMC_SYS_LMODE);
    end
  end

  assign buck_pair_mode_ctrl   = b2_view;
  assign buck_trio_mode_ctrl   = b3_view;
  assign linear_voltage_select = lv_reg & `RMC_MASK_LVSEL;
  assign boost_ctrl = (bst_reg & `RMC_SYS_BOOST) | {22'h0, bst_set_reg};
  assign linear_mode_ctrl = (((lm_reg & `RMC_SYS_LMODE)
                            | (lm_keep_reg & `RMC_MASK_LMODE
                               & ~`RMC_SYS_LMODE))
                            & ~(24'h1 << `RMC_BIT_USBROLE))
                          | ({23'h0, usb_role_reg} << `RMC_BIT_USBROLE);

  always_comb begin
    rdata_next = '0; // unmapped reads as zero
    if (!bus.rd) begin
      rdata_next = '0;
    end else if (bus.addr == `RMC_OFF_BUCK2) begin
      rdata_next = buck_pair_mode_ctrl;
    end else if (bus.addr == `RMC_OFF_BUCK3) begin
      rdata_next = buck_trio_mode_ctrl;
    end else if (bus.addr == `RMC_OFF_LVSEL) begin
      rdata_next = linear_voltage_select;
    end else if (bus.addr == `RMC_OFF_BOOST) begin
      rdata_next = boost_ctrl;
    end else if (bus.addr == `RMC_OFF_LMODE) begin
      rdata_next = linear_mode_ctrl;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= rdata_next;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      load_done <= 1'b0;
    end else if (load_pulse) begin
      load_done <= 1'b1;
    end
  end

  rst_defaults_a: assert property (
    @(posedge clk) disable iff (rst)
    $fell(rst) |-> buck_pair_mode_ctrl[3:0] == `RMC_MODE_DEF)
    else $error("buck 1a mode not at default");
  unused_zero_a: assert property (
    @(posedge clk) disable iff (rst)
    buck_pair_mode_ctrl[13:8] == 6'h0)
    else $error("unused bits not zero");
  seq_aps_a: assert property (
    @(posedge clk) disable iff (rst)
    load_pulse && seq.buck_on[2] |=> b3_view[3:0] == `RMC_MODE_APS)
    else $error("enabled buck not aps");
  seq_load_a: assert property (
    @(posedge clk) disable iff (rst)
    load_pulse |=> b2_view[17:14] == seq_mode($past(seq.buck_on[1])))
    else $error("buck two mode not loaded");
  usb_force_a: assert property (
    @(posedge clk) disable iff (rst)
    vbus_invalid |=> linear_mode_ctrl[`RMC_BIT_USBON])
    else $error("usb supply not forced on");
  pass_strap_a: assert property (
    @(posedge clk) disable iff (rst)
    load_pulse |=> linear_mode_ctrl[`RMC_BIT_G2PASS] == strap_reg
      && linear_mode_ctrl[`RMC_BIT_U2PASS] == strap_reg)
    else $error("pass select differs from strap");
  boost_mode_a: assert property (
    @(posedge clk) disable iff (rst)
    $fell(rst) |-> boost_ctrl[3:2] == `RMC_BST_DEF
      && boost_ctrl[6:5] == `RMC_BST_DEF)
    else $error("boost modes not at default");
  lv_unused_a: assert property (
    @(posedge clk) disable iff (rst)
    linear_voltage_select[3] == 1'b0
      && linear_voltage_select[23:13] == 11'h0)
    else $error("voltage select unused bits set");
  stby_clear_a: assert property (
    @(posedge clk) disable iff (rst)
    $fell(rst) |-> linear_mode_ctrl[19] == 1'b0
      && linear_mode_ctrl[1] == 1'b0)
    else $error("standby control not cleared");
endmodule

// File: dv/testbench.sv
/*
  self-checking bench for the regulator mode control register bank.
  assumes rmc_pkg and rmc_defs.svh are compiled first; reads are checked
  by a monitor that pops expected values queued by the read task.
*/
`timescale 1ns/1ns
`include "rmc_defs.svh"
module testbench;
  import rmc_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        power_off_rst = 1'b1;
  rmc_req_t    bus = '0;
  rmc_seq_t    seq = '0;
  logic        seq_req = 1'b0;
  logic        pass_device_strap = 1'b0;
  logic        vbus_invalid = 1'b0;
  logic [23:0] rdata;
  logic        load_done;
  logic        rd_seen = 1'b0;
  logic [23:0] exp_q[$];
  logic [23:0] msk_q[$];
  int          n_errors = 0;
  int          total_checks = 0;
  int          cyc = 0;
  logic [23:0] d;
  logic [7:0]  offs[5] = '{8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h20};
  logic [23:0] wmsk[5] = '{24'hffc0ff, 24'hffffff, 24'h001ff7, 24'h0000ff,
                           24'h1ffc7f};

  always #5 clk = ~clk;

  rmc_regs rmc_regs_inst (
    .clk                   (clk),
    .rst                   (rst),
    .power_off_rst         (power_off_rst),
    .bus                   (bus),
    .seq                   (seq),
    .seq_req               (seq_req),
    .pass_device_strap     (pass_device_strap),
    .vbus_invalid          (vbus_invalid),
    .rdata                 (rdata),
    .buck_pair_mode_ctrl   (),
    .buck_trio_mode_ctrl   (),
    .linear_voltage_select (),
    .boost_ctrl            (),
    .linear_mode_ctrl      (),
    .load_done             (load_done)
  );

  task automatic stop_test();
    if (n_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // read data stand only in the cycle after the read strobe
  always @(posedge clk) begin
    if (rd_seen) begin
      total_checks++;
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("unexpected %0t read data with no pending read", $time);
      end else if ((rdata & msk_q[0]) !== (exp_q[0] & msk_q[0])) begin
        n_errors++;
        $display("unexpected %0t rdata %h expected %h mask %h", $time,
                 rdata, exp_q[0], msk_q[0]);
      end
      if (exp_q.size() != 0) begin
        void'(exp_q.pop_front());
        void'(msk_q.pop_front());
      end
    end
    rd_seen <= bus.rd;
  end

  // ceiling is well above the roughly 130 cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [23:0] v);
    @(posedge clk);
    bus.addr  <= a;
    bus.wdata <= v;
    bus.wr    <= 1'b1;
    @(posedge clk);
    bus.wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [23:0] e,
                    input logic [23:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clk);
    bus.rd   <= 1'b0;
  endtask

  task automatic do_rst(input logic sys, input logic off);
    repeat (2) @(posedge clk);
    rst           <= sys;
    power_off_rst <= off;
    repeat (3) @(posedge clk);
    rst           <= 1'b0;
    power_off_rst <= 1'b0;
  endtask

  function automatic logic [23:0] md(input logic on);
    // enabled buck gets auto pulse-skip, a disabled one the off code
    return on ? 24'h8 : 24'h0;
  endfunction

  initial begin
    d = $urandom(32'hbbbd);
    repeat (3) @(posedge clk);
    rst           <= 1'b0;
    power_off_rst <= 1'b0;
    rd(`RMC_OFF_BUCK2, 24'h52804a, 24'hffffff);
    rd(`RMC_OFF_BUCK3, 24'h28a28a, 24'hffffff);
    rd(`RMC_OFF_LVSEL, 24'h000000, 24'hffe008);
    rd(`RMC_OFF_BOOST, 24'h000048, 24'hfffffc);
    rd(`RMC_OFF_LMODE, 24'h000008, 24'hf963ea);
    rd(8'h21, 24'h000000, 24'hffffff);
    for (int i = 0; i < 5; i++) begin
      d = $urandom();
      wr(offs[i], d);
      rd(offs[i], d & wmsk[i], 24'hffffff);
    end
    for (int i = 0; i < 5; i++) begin
      wr(offs[i], 24'hffffff);
    end
    // system reset alone keeps hold, user-off and unreset fields
    do_rst(1'b1, 1'b0);
    rd(`RMC_OFF_BUCK2, 24'h5e807a, 24'hffffff);
    rd(`RMC_OFF_BUCK3, 24'hebaeba, 24'hffffff);
    rd(`RMC_OFF_BOOST, 24'h00004b, 24'hffffff);
    rd(`RMC_OFF_LMODE, 24'h069c1d, 24'hffffff);
    do_rst(1'b0, 1'b1);
    rd(`RMC_OFF_BUCK2, 24'h52804a, 24'h0c0030);
    rd(`RMC_OFF_BUCK3, 24'h28a28a, 24'hc30c30);
    wr(`RMC_OFF_LMODE, 24'h000000);
    rd(`RMC_OFF_LMODE, 24'h000000, 24'h000008);
    @(posedge clk);
    vbus_invalid <= 1'b1;
    rd(`RMC_OFF_LMODE, 24'h000008, 24'h000008);
    wr(`RMC_OFF_LMODE, 24'h000000);
    rd(`RMC_OFF_LMODE, 24'h000008, 24'h000008);
    vbus_invalid <= 1'b0;
    wr(`RMC_OFF_LMODE, 24'h000000);
    rd(`RMC_OFF_LMODE, 24'h000000, 24'h000008);
    for (int s = 0; s < 2; s++) begin
      repeat (2) @(posedge clk);
      seq               <= rmc_seq_t'(25'($urandom()));
      pass_device_strap <= s[0];
      do_rst(1'b1, 1'b0);
      @(posedge clk);
      seq_req <= 1'b1;
      for (int k = 0; k < 20 && load_done !== 1'b1; k++) begin
        @(posedge clk);
      end
      seq_req <= 1'b0;
      if (load_done !== 1'b1) begin
        n_errors++;
        $display("unexpected %0t start-up load never completed", $time);
      end
      rd(`RMC_OFF_BUCK2, md(seq.buck_on[0]) | (md(seq.buck_on[1]) << 14),
         24'h03c00f);
      rd(`RMC_OFF_BUCK3, md(seq.buck_on[2]) | (md(seq.buck_on[3]) << 6)
         | (md(seq.buck_on[4]) << 12) | (md(seq.buck_on[5]) << 18),
         24'h3cf3cf);
      rd(`RMC_OFF_BOOST, {22'h0, seq.boost_set}, 24'h000003);
      rd(`RMC_OFF_LVSEL, {11'h0, seq.lvsel[7:6], 1'b0, seq.lvsel[5:0],
         4'h0}, 24'h001bf0);
      d = {5'h0, seq.lin_on[5], s[0], 1'b0, seq.lin_on[4], 2'h0,
           seq.lin_on[3], s[0], seq.lin_on[2], 5'h0, seq.lin_on[1], 1'b0,
           seq.usb_role, 1'b0, seq.lin_on[0]};
      rd(`RMC_OFF_LMODE, d, 24'h069c15);
    end
    repeat (3) @(posedge clk);
    stop_test();
  end
endmodule
